// *** hw/drs_map.svh ***
`ifndef DRS_MAP_SVH
`define DRS_MAP_SVH

// ---------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------
`define DRS_OFF_CTRL     5'h00
`define DRS_OFF_OP_TIME  5'h04
`define DRS_OFF_BRK_TIME 5'h08
`define DRS_OFF_STATUS   5'h0c
`define DRS_OFF_ELAPSED  5'h10

// ---------------------------------------------
// field positions and widths
// ---------------------------------------------
`define DRS_CTRL_MODE_LSB 0
`define DRS_CTRL_SEL_LSB  4
`define DRS_FINE_W        16
`define DRS_TIMER_W       26
`define DRS_RANGE_SHIFT   3

// ---------------------------------------------
// reset values and selector codes
// ---------------------------------------------
`define DRS_CTRL_RST      3'h0
`define DRS_SEL_RST       3'h0
`define DRS_FINE_RST      16'h000a
`define DRS_SEL_FORCE_OFF 3'h6
`define DRS_SEL_FORCE_ON  3'h7

// ---------------------------------------------
// timing
// ---------------------------------------------
`define DRS_CLK_PERIOD_NS  50
`define DRS_TICK_PERIOD_NS 100000000
`define DRS_TICK_CYCLES \
  ((`DRS_TICK_PERIOD_NS + `DRS_CLK_PERIOD_NS - 1) / `DRS_CLK_PERIOD_NS)
`define DRS_HOLD_MAX_MIN   10
`define DRS_HOLD_MAX_TICKS (`DRS_HOLD_MAX_MIN * 600)

`endif

// *** hw/drs_pkg.sv ***
// ---------------------------------------------
// shared types
// ---------------------------------------------
package drs_pkg;

  // sequencer states, gray along off-ph1-ph2-done
  typedef enum logic [2:0] {
    DRS_ST_OFF  = 3'b000,
    DRS_ST_PH1  = 3'b001,
    DRS_ST_PH2  = 3'b011,
    DRS_ST_DONE = 3'b010,
    DRS_ST_HOLD = 3'b110
  } drs_state_t;

  // operating modes
  typedef enum logic [2:0] {
    DRS_MD_OFF_DLY = 3'h0,
    DRS_MD_ON_DLY  = 3'h1,
    DRS_MD_CYC_OFF = 3'h2,
    DRS_MD_CYC_ON  = 3'h3,
    DRS_MD_HOLD1   = 3'h4,
    DRS_MD_HOLD2   = 3'h5,
    DRS_MD_HOLD3   = 3'h6
  } drs_mode_t;

endpackage : drs_pkg

// *** hw/drs_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// tenth-second time base
// ---------------------------------------------
module drs_tick_gen #(
  parameter int unsigned TICK_CYCLES = 2000000
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic clr_i,
  // time base out
  output logic      tick_o
);

  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

  logic [CW-1:0] div_q;   // prescaler
  logic [CW-1:0] div_d;
  logic          tick_q;  // one-cycle pulse
  logic          tick_d;

  // restart on clear so a phase starts on a full period
  always_comb begin
    div_d  = div_q + CW'(1);
    tick_d = 1'b0;
    if (clr_i) begin
      div_d = '0;
    end else if (div_q == CW'(TICK_CYCLES - 1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule : drs_tick_gen

`default_nettype wire

// *** hw/drs_sequencer.sv ***
// Operation
// - selector forced-on closes contact while powered
// - selector forced-off opens contact while powered
// - range changes while powered are ignored
// - range sampled only at power-up
// - fine time adjustable live, used immediately
// - hold after supply loss at most ten minutes
// - hold one: closed on power, hold after loss
// - hold two: plain on-delay, no hold
// - hold three: on-delay, then hold after loss
// - off-delay: energize operating time, release break
// - off-delay: then energized until power cycled
// - on-delay: released for operating time first
// - on-delay: energize break time, then released
// - one-shot runs once per power-up
// - cyclic off-delay repeats on/off forever
// - cyclic on-delay repeats off/on forever
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "drs_map.svh"

module drs_sequencer #(
  parameter int unsigned TICK_CYCLES = `DRS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // supply sense pin
  input  wire logic        supply_present_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // relay and state
  output logic             relay_o,
  output drs_pkg::drs_state_t state_o
);
  import drs_pkg::*;

  localparam int TW = `DRS_TIMER_W;
  localparam int FW = `DRS_FINE_W;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // fine setting scaled by range, zero read as a fine value of one
  function automatic logic [TW-1:0] scale_dur(
    input logic [FW-1:0] fine,
    input logic [2:0]    sel
  );
    logic [TW-1:0] base;
    logic [1:0]    rng;
    base = (fine == '0) ? TW'(1) : TW'(fine);
    rng  = sel[2] ? 2'h3 : sel[1:0];
    scale_dur = base << (`DRS_RANGE_SHIFT * rng);
  endfunction : scale_dur

  // contact level belonging to a state and mode
  function automatic logic relay_of(
    input drs_state_t st,
    input drs_mode_t  md
  );
    case (st)
      DRS_ST_PH1:  relay_of = (md == DRS_MD_OFF_DLY) ||
                              (md == DRS_MD_CYC_OFF);
      DRS_ST_PH2:  relay_of = (md == DRS_MD_ON_DLY) ||
                              (md == DRS_MD_CYC_ON);
      DRS_ST_DONE: relay_of = (md != DRS_MD_ON_DLY);
      DRS_ST_HOLD: relay_of = 1'b1;
      default:     relay_of = 1'b0;
    endcase
  endfunction : relay_of

  // ---------------------------------------------
  // supply sense synchroniser
  // ---------------------------------------------
  logic sup_s1_q;   // first stage, read by sup_s2_q only
  logic sup_s2_q;   // synchronised level
  logic sup_prev_q; // for edge detect
  logic power_up;
  logic power_dn;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sup_s1_q   <= 1'b0;
      sup_s2_q   <= 1'b0;
      sup_prev_q <= 1'b0;
    end else begin
      sup_s1_q   <= supply_present_i;
      sup_s2_q   <= sup_s1_q;
      sup_prev_q <= sup_s2_q;
    end
  end

  assign power_up = sup_s2_q & ~sup_prev_q;
  assign power_dn = ~sup_s2_q & sup_prev_q;

  // ---------------------------------------------
  // register file and bus slave
  // ---------------------------------------------
  logic [2:0]    mode_q;  // selector mode, live
  logic [2:0]    mode_d;
  logic [2:0]    sel_q;   // range selector, live
  logic [2:0]    sel_d;
  logic [FW-1:0] op_q;    // operating_time fine
  logic [FW-1:0] op_d;
  logic [FW-1:0] brk_q;   // break_time fine
  logic [FW-1:0] brk_d;
  logic          ack_q;   // second cycle of access
  logic          ack_d;
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;
  logic          req;

  // sequencer state, declared here for readback
  drs_state_t    st_q;
  drs_state_t    st_d;
  drs_mode_t     mode_lat_q;
  drs_mode_t     mode_lat_d;
  logic [2:0]    sel_lat_q;
  logic [2:0]    sel_lat_d;
  logic [TW-1:0] cnt_q;
  logic [TW-1:0] cnt_d;
  logic          relay_q;
  logic          relay_d;

  assign req = avs_read_i | avs_write_i;

  // one wait cycle: data is ready on the edge that ends it
  assign avs_waitrequest_o = req & ~ack_q;

  always_comb begin
    mode_d  = mode_q;
    sel_d   = sel_q;
    op_d    = op_q;
    brk_d   = brk_q;
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    if (req && !ack_q && avs_read_i) begin
      // capture read data in the wait cycle
      if (avs_address_i == `DRS_OFF_CTRL) begin
        rdata_d = {25'h0, sel_q, 1'b0, mode_q};
      end else if (avs_address_i == `DRS_OFF_OP_TIME) begin
        rdata_d = {16'h0, op_q};
      end else if (avs_address_i == `DRS_OFF_BRK_TIME) begin
        rdata_d = {16'h0, brk_q};
      end else if (avs_address_i == `DRS_OFF_STATUS) begin
        rdata_d = {20'h0, sel_lat_q, 1'b0, mode_lat_q,
                   st_q, sup_s2_q, relay_q};
      end else if (avs_address_i == `DRS_OFF_ELAPSED) begin
        rdata_d = {6'h0, cnt_q};
      end else begin
        rdata_d = 32'h0;      // unmapped reads zero
      end
    end
    if (ack_q && avs_write_i) begin
      // write takes effect on the edge with waitrequest low
      if (avs_address_i == `DRS_OFF_CTRL) begin
        mode_d = avs_writedata_i[`DRS_CTRL_MODE_LSB +: 3];
        sel_d  = avs_writedata_i[`DRS_CTRL_SEL_LSB +: 3];
      end else if (avs_address_i == `DRS_OFF_OP_TIME) begin
        op_d = avs_writedata_i[FW-1:0];   // live trim
      end else if (avs_address_i == `DRS_OFF_BRK_TIME) begin
        brk_d = avs_writedata_i[FW-1:0];  // live trim
      end
      // other offsets are read-only or unmapped: ignored
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q  <= `DRS_CTRL_RST;
      sel_q   <= `DRS_SEL_RST;
      op_q    <= `DRS_FINE_RST;
      brk_q   <= `DRS_FINE_RST;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      mode_q  <= mode_d;
      sel_q   <= sel_d;
      op_q    <= op_d;
      brk_q   <= brk_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_o = rdata_q;

  // ---------------------------------------------
  // time base
  // ---------------------------------------------
  logic tick;

  // realign on each supply edge so phases last whole ticks
  drs_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clr_i     (power_up | power_dn),
    .tick_o    (tick)
  );

  // ---------------------------------------------
  // phase durations
  // ---------------------------------------------
  logic [TW-1:0] dur_op;    // operating_time in ticks
  logic [TW-1:0] dur_brk;   // break_time in ticks
  logic [TW-1:0] dur_hold;  // capped hold time
  logic [TW-1:0] cnt_inc;

  // range from the latch, fine value live
  assign dur_op  = scale_dur(op_q, sel_lat_q);
  assign dur_brk = scale_dur(brk_q, sel_lat_q);
  // hold may never outlast the backup supply
  assign dur_hold = (dur_op > TW'(`DRS_HOLD_MAX_TICKS)) ?
                    TW'(`DRS_HOLD_MAX_TICKS) : dur_op;
  assign cnt_inc = cnt_q + TW'(1);

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  // >= so a live shortening ends the phase on the next tick
  always_comb begin
    st_d       = st_q;
    mode_lat_d = mode_lat_q;
    sel_lat_d  = sel_lat_q;
    cnt_d      = tick ? cnt_inc : cnt_q;
    case (st_q)
      DRS_ST_PH1: begin
        if (tick && cnt_inc >= dur_op) begin
          cnt_d = '0;
          if (mode_lat_q == DRS_MD_HOLD2 ||
              mode_lat_q == DRS_MD_HOLD3) begin
            st_d = DRS_ST_DONE;
          end else begin
            st_d = DRS_ST_PH2;
          end
        end
      end
      DRS_ST_PH2: begin
        if (tick && cnt_inc >= dur_brk) begin
          cnt_d = '0;
          if (mode_lat_q == DRS_MD_CYC_OFF ||
              mode_lat_q == DRS_MD_CYC_ON) begin
            st_d = DRS_ST_PH1;
          end else begin
            st_d = DRS_ST_DONE;
          end
        end
      end
      DRS_ST_HOLD: begin
        if (tick && cnt_inc >= dur_hold) begin
          st_d  = DRS_ST_OFF;
          cnt_d = '0;
        end
      end
      DRS_ST_DONE: begin
        cnt_d = cnt_q;                 // one-shot parks
      end
      default: begin
        cnt_d = '0;                    // unpowered, idle
      end
    endcase
    // supply loss ends the run, maybe into hold
    if (power_dn && st_q != DRS_ST_OFF &&
        st_q != DRS_ST_HOLD) begin
      cnt_d = '0;
      if (mode_lat_q == DRS_MD_HOLD1 ||
          mode_lat_q == DRS_MD_HOLD3) begin
        st_d = DRS_ST_HOLD;
      end else begin
        st_d = DRS_ST_OFF;
      end
    end
    // power-up latches mode and range, starts the run
    if (power_up) begin
      mode_lat_d = drs_mode_t'(mode_q);
      sel_lat_d  = sel_q;
      cnt_d      = '0;
      if (drs_mode_t'(mode_q) == DRS_MD_HOLD1) begin
        st_d = DRS_ST_DONE;
      end else begin
        st_d = DRS_ST_PH1;
      end
    end
  end

  // output: forced selector positions act on live value
  always_comb begin
    relay_d = relay_of(st_d, mode_lat_d);
    if (sup_s2_q && sel_q == `DRS_SEL_FORCE_ON) begin
      relay_d = 1'b1;
    end else if (sup_s2_q && sel_q == `DRS_SEL_FORCE_OFF) begin
      relay_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q       <= DRS_ST_OFF;
      mode_lat_q <= DRS_MD_OFF_DLY;
      sel_lat_q  <= `DRS_SEL_RST;
      cnt_q      <= '0;
      relay_q    <= 1'b0;
    end else begin
      st_q       <= st_d;
      mode_lat_q <= mode_lat_d;
      sel_lat_q  <= sel_lat_d;
      cnt_q      <= cnt_d;
      relay_q    <= relay_d;
    end
  end

  assign relay_o = relay_q;
  assign state_o = st_q;

endmodule : drs_sequencer

`default_nettype wire

// *** dv/drs_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// external load behind the relay contact
// ---------------------------------------------
module drs_load_model #(
  parameter int unsigned SETTLE = 2  // contact travel, in clocks
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // contact
  input  wire logic       relay_i,
  // load view
  output logic            load_on_o,
  output logic      [7:0] closures_o
);
  logic [SETTLE-1:0] pipe_q;  // mechanical lag, load never follows at once

  // lag the contact, count each closing of the load
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe_q     <= '0;
      closures_o <= 8'h00;
    end else begin
      pipe_q <= {pipe_q[SETTLE-2:0], relay_i};
      if (pipe_q[SETTLE-1:SETTLE-2] == 2'b01) begin  // load just closed
        closures_o <= closures_o + 8'h01;
      end
    end
  end
  assign load_on_o = pipe_q[SETTLE-1];
endmodule : drs_load_model

`default_nettype wire

// *** dv/drs_sequencer_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// port checks of the relay sequencer
// ---------------------------------------------
module drs_seq_sva
  import drs_pkg::*;
(
  // clock, reset, supply
  input wire logic         sys_clk_i,
  input wire logic         rst_n_i,
  input wire logic         supply_present_i,
  // bus
  input wire logic         avs_read_i,
  input wire logic         avs_write_i,
  input wire logic [31:0]  avs_readdata_o,
  input wire logic         avs_waitrequest_o,
  // relay side
  input wire logic         relay_o,
  input wire logic [2:0]   state_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic req;  // any bus request
  assign req = avs_read_i | avs_write_i;

  a_wait_once: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest longer than one cycle");
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("request answered without wait");
  a_idle_ready: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  a_rdata_stand: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without read");
  a_hold_closed: assert property (state_o == DRS_ST_HOLD |-> relay_o)
    else $error("hold state with open contact");
  a_unpowered: assert property (!supply_present_i [*4] |->
    relay_o == (state_o == DRS_ST_HOLD))
    else $error("contact wrong without supply");
  a_power_up: assert property ($rose(supply_present_i) |->
    ##[1:4] state_o != DRS_ST_OFF)
    else $error("no start after supply rise");
  a_power_loss: assert property ($fell(supply_present_i) |->
    ##[1:4] state_o inside {DRS_ST_OFF, DRS_ST_HOLD})
    else $error("no stop after supply loss");
  a_done_stays: assert property ((supply_present_i [*3] ##0
    state_o == DRS_ST_DONE) |=> state_o == DRS_ST_DONE)
    else $error("one-shot restarted while powered");
  // hold is entered only three edges after the pin was seen low
  a_hold_entry: assert property ((state_o == DRS_ST_HOLD &&
    $past(state_o) != DRS_ST_HOLD) |-> !$past(supply_present_i, 3))
    else $error("hold entered while supplied");

  c_hold: cover property (state_o == DRS_ST_HOLD);
  c_bus: cover property (req && !avs_waitrequest_o);
  c_cycle: cover property (state_o == DRS_ST_PH2 ##1 state_o == DRS_ST_PH1);
endmodule : drs_seq_sva

bind drs_sequencer drs_seq_sva i_drs_seq_sva (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .supply_present_i(supply_present_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .relay_o(relay_o),
  .state_o(state_o));

`default_nettype wire

// *** dv/tb_dual_time_relay_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_dual_time_relay_sequencer;
  import drs_pkg::*;
  localparam int TC = 10;  // short time base, 10 clocks a tick
  logic        sys_clk, rst_n, supply, avs_read, avs_write;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, readdata, rdat, rd_s, r;
  logic        waitreq, relay, relay_s, wait_s, e;
  logic [7:0]  closures, c0;
  drs_state_t  state, state_s;
  int          mismatches, num_checks, cyc, t0, m, j, tt, op, br;
  logic [31:0] seed = 32'h40cbd3e2;

  // ---------------------------------------------
  // design and load
  // ---------------------------------------------
  drs_sequencer #(.TICK_CYCLES(TC)) i_drs_sequencer (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .supply_present_i(supply),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq),
    .relay_o(relay), .state_o(state));
  drs_load_model i_drs_load_model (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .relay_i(relay), .load_on_o(), .closures_o(closures));

  always #25 sys_clk = ~sys_clk;
  // settled copies, avoids races with the edge's own updates
  always @(negedge sys_clk) begin
    wait_s = waitreq;
    rd_s = readdata;
    relay_s = relay;
    state_s = state;
  end
  // hang guard, about three times the scripted run; non-blocking so that
  // tasks reading cyc on the same edge always see the old count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // reference contact level, t and times in clocks
  function automatic logic exp_relay(int md, int t, int o, int b);
    case (md)
      0: return (t < o) || (t >= o + b);
      1: return (t >= o) && (t < o + b);
      2: return (t % (o + b)) < o;
      3: return (t % (o + b)) >= o;
      4: return 1'b1;
      default: return t >= o;
    endcase
  endfunction : exp_relay
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // no cycle count assumed: only the hang guard bounds this wait
    do begin
      @(posedge sys_clk);
    end while (wait_s !== 1'b0);
    rdat = rd_s;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wait_to(input int t);
    while (cyc - t0 < t) @(posedge sys_clk);
  endtask : wait_to
  // hold counts as stopped, so timing starts once the new state is seen
  task automatic power(input logic on);
    supply <= on;
    do begin
      @(posedge sys_clk);
    end while ((state_s inside {DRS_ST_OFF, DRS_ST_HOLD}) == on);
    t0 = cyc;
  endtask : power
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {sys_clk, rst_n, supply, avs_read, avs_write} = '0;
    avs_address = '0;
    avs_writedata = '0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, 5'h04, 0);
    check("op reset", rdat, 32'h0000000a);
    bus(1'b0, 5'h14, 0);
    check("unmapped", rdat, 32'h0);
    bus(1'b1, 5'h0c, 32'hffff);
    bus(1'b0, 5'h0c, 0);
    check("status", rdat, 32'h0);
    // every mode, random operating and break times
    for (m = 0; m < 7; m++) begin
      r = xs();
      op = 3 + r % 3;
      br = 4 + (r >> 8) % 3;
      bus(1'b1, 5'h00, m);
      bus(1'b1, 5'h04, op);
      bus(1'b1, 5'h08, br);
      c0 = closures;
      power(1'b1);
      for (j = 0; j < 4; j++) begin
        tt = (j > 1 ? (op + br) * 10 : 0) + (j % 2 ? op * 10 + br * 5 : op * 5);
        wait_to(tt);
        e = exp_relay(m, tt, op * 10, br * 10);
        check("relay", relay_s, e);
        if (j == 1) begin
          bus(1'b0, 5'h0c, 0);
          check("latched mode", rdat[7:5], m[2:0]);
        end
      end
      if (m < 4) check("closures", closures - c0, m == 1 ? 1 : 2);
      power(1'b0);
      wait_to(20);
      check("held", relay_s, m == 4 || m == 6);
      check("stop state", state_s, (m == 4 || m == 6) ? DRS_ST_HOLD : DRS_ST_OFF);
      wait_to(op * 10 + 40);
      check("released", relay_s, 1'b0);
    end
    // range latched, fine trimmed live, forced positions
    bus(1'b1, 5'h04, 32'h4);
    bus(1'b1, 5'h00, 32'h01);
    power(1'b1);
    bus(1'b1, 5'h00, 32'h11);
    wait_to(60);
    check("range kept", relay_s, 1'b1);
    power(1'b0);
    power(1'b1);
    wait_to(60);
    check("new range", relay_s, 1'b0);
    bus(1'b1, 5'h04, 32'h1);
    wait_to(120);
    check("fine trim", relay_s, 1'b1);
    bus(1'b1, 5'h00, 32'h61);
    repeat (4) @(posedge sys_clk);
    check("forced off", relay_s, 1'b0);
    bus(1'b1, 5'h00, 32'h71);
    repeat (4) @(posedge sys_clk);
    check("forced on", relay_s, 1'b1);
    tally_and_finish();
  end
endmodule : tb_dual_time_relay_sequencer

`default_nettype wire
